// *** shared/pmwrc_pkg.sv ***
// package: register map, field positions, reset values and timing for pmwrc
package pmwrc_pkg;
   // register byte offset and a spare offset for the wake status mirror
   localparam logic [11:0] PMWRC_CTL_OFS = 12'h014;
   localparam logic [11:0] PMWRC_WAKE_OFS = 12'h020;
   // field positions in the power management control word
   localparam int PMWRC_CAUSE_LO = 0;
   localparam int PMWRC_PHYIRQ_EN_BIT = 2;
   localparam int PMWRC_LAN_EN_BIT = 3;
   localparam int PMWRC_PHY_RESET_TRIGGER_BIT = 4;
   localparam int PMWRC_LPSEL_LO = 5;
   localparam int PMWRC_READY_BIT = 7;
   localparam int PMWRC_RCE_BIT = 8;
   localparam int PMWRC_RCS_BIT = 9;
   localparam int PMWRC_EEE_CAUSE_BIT = 12;
   // reset values
   localparam logic [1:0] PMWRC_LPSEL_RST = 2'h2;
   localparam logic PMWRC_RCE_RST = 1'b1;
   localparam logic PMWRC_RCS_RST = 1'b0;
   // low-power state codes; zero and one behave the same
   localparam logic [1:0] PMWRC_LP_ZERO = 2'h0;
   localparam logic [1:0] PMWRC_LP_ONE = 2'h1;
   localparam logic [1:0] PMWRC_LP_TWO = 2'h2;
   localparam logic [1:0] PMWRC_LP_THREE = 2'h3;
   // width of the wake status mirror (nine listed statuses)
   localparam int PMWRC_NSTS = 9;
   // phy reset hold time
   localparam int PMWRC_CLK_MHZ = 100;
   localparam int PMWRC_PHY_RESET_TRIGGER_US = 4000;
   localparam int PMWRC_PHY_RESET_TRIGGER_CYC = PMWRC_PHY_RESET_TRIGGER_US * PMWRC_CLK_MHZ;
endpackage

// *** hw/pmwrc_top.sv ***
// power management wake, ready and phy reset control with ahb-lite slave
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - status-clear control set: remote-wake resume clears all listed wake statuses
// - same resume also clears wake cause bit one and energy wake cause
// - host-started resumes never clear any wake status
// - status-clear control cleared: statuses kept after every resume
// - enable-clear control, reset one, clears wake enables after remote resume
// - host-started resumes never clear any wake enable
// - ready reads zero at reset, low during phy reset and config load
// - two-bit low-power select, reset value two, read/write
// - entering unconfigured state forces low-power select back to two
// - low-power codes zero and one behave identically
// - writing phy reset holds the low pin at least 4 ms, self-clears
// - writes to phy reset are ignored while it reads one
// - setting phy reset clears ready at once, ready returns afterwards
// - lan wake enable, read/write, reset zero, gates lan wake sources
// - phy interrupt wake enable, read/write, reset zero, gates phy wake
// - both wake enables self-clear on remote resume if enable-clear set
// - wake cause bits clear by writing one, zero leaves them
module pmwrc_top import pmwrc_pkg::*; #(
   parameter int PHY_RESET_TRIGGER_CYC = PMWRC_PHY_RESET_TRIGGER_CYC
) (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   input wire logic resume_done_in,
   input wire logic resume_remote_in,
   input wire logic enter_unconfig_in,
   input wire logic cfg_loading_in,
   input wire logic [PMWRC_NSTS-1:0] wake_sts_set_in,
   input wire logic [1:0] wake_cause_set_in,
   input wire logic eee_cause_set_in,
   output logic [PMWRC_NSTS-1:0] wake_sts_out,
   output logic [1:0] low_power_sel_out,
   output logic lan_wake_enable_out,
   output logic phy_irq_wake_enable_out,
   output logic device_ready_out,
   output logic phy_reset_pin_low_out
);
   // registers
   logic resume_clears_status_r;
   logic resume_clears_enables_r;
   logic [1:0] low_power_sel_r;
   logic lan_wake_enable_r;
   logic phy_irq_wake_enable_r;
   logic phy_reset_trigger_r;
   logic [31:0] phy_cnt_r;
   logic [1:0] wake_cause_r;
   logic eee_cause_r;
   logic [PMWRC_NSTS-1:0] wake_sts_r;
   logic device_ready_r;
   logic [31:0] hrdata_r;
   // ahb address phase capture
   logic wr_pend_r;
   logic [11:0] wr_addr_r;
   logic rd_go;
   logic [31:0] rd_word;
   logic ctl_wr;
   logic sts_wr;
   logic remote_done;
   logic host_done;

   // decode of a word offset within the block
   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a[11:2] == o[11:2]);
   endfunction

   // ahb-lite slave: zero wait states, always okay
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign rd_go = hsel_in && hready_in && htrans_in[1] && !hwrite_in;
   assign ctl_wr = wr_pend_r && hit(wr_addr_r, PMWRC_CTL_OFS);
   assign sts_wr = wr_pend_r && hit(wr_addr_r, PMWRC_WAKE_OFS);
   assign remote_done = resume_done_in && resume_remote_in;
   assign host_done = resume_done_in && !resume_remote_in;

   // capture of a write address phase
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 12'h000;
      end else begin
         wr_pend_r <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
         wr_addr_r <= haddr_in[11:0];
      end
   end

   // read mux; unmapped reads return zero
   always_comb begin
      rd_word = 32'h00000000;
      if (hit(haddr_in[11:0], PMWRC_CTL_OFS)) begin
         rd_word[PMWRC_CAUSE_LO +: 2] = wake_cause_r;
         rd_word[PMWRC_PHYIRQ_EN_BIT] = phy_irq_wake_enable_r;
         rd_word[PMWRC_LAN_EN_BIT] = lan_wake_enable_r;
         rd_word[PMWRC_PHY_RESET_TRIGGER_BIT] = phy_reset_trigger_r;
         rd_word[PMWRC_LPSEL_LO +: 2] = low_power_sel_r;
         rd_word[PMWRC_READY_BIT] = device_ready_r;
         rd_word[PMWRC_RCE_BIT] = resume_clears_enables_r;
         rd_word[PMWRC_RCS_BIT] = resume_clears_status_r;
         rd_word[PMWRC_EEE_CAUSE_BIT] = eee_cause_r;
      end else if (hit(haddr_in[11:0], PMWRC_WAKE_OFS)) begin
         rd_word[PMWRC_NSTS-1:0] = wake_sts_r;
      end
   end

   // read data registered for the data phase
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         hrdata_r <= 32'h00000000;
      end else if (rd_go) begin
         hrdata_r <= rd_word;
      end
   end
   assign hrdata_out = hrdata_r;

   // resume control bits
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         resume_clears_status_r <= PMWRC_RCS_RST;
         resume_clears_enables_r <= PMWRC_RCE_RST;
      end else if (ctl_wr) begin
         resume_clears_status_r <= hwdata_in[PMWRC_RCS_BIT];
         resume_clears_enables_r <= hwdata_in[PMWRC_RCE_BIT];
      end
   end

   // low-power select; unconfigured entry wins over a write
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         low_power_sel_r <= PMWRC_LPSEL_RST;
      end else if (enter_unconfig_in) begin
         low_power_sel_r <= PMWRC_LPSEL_RST;
      end else if (ctl_wr) begin
         low_power_sel_r <= hwdata_in[PMWRC_LPSEL_LO +: 2];
      end
   end
   // codes zero and one reach the power logic as the same state
   assign low_power_sel_out = (low_power_sel_r == PMWRC_LP_ONE) ?
      PMWRC_LP_ZERO : low_power_sel_r;

   // wake enables, cleared by a remote resume only
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         lan_wake_enable_r <= 1'b0;
         phy_irq_wake_enable_r <= 1'b0;
      end else if (remote_done && resume_clears_enables_r) begin
         lan_wake_enable_r <= 1'b0;
         phy_irq_wake_enable_r <= 1'b0;
      end else if (ctl_wr) begin
         lan_wake_enable_r <= hwdata_in[PMWRC_LAN_EN_BIT];
         phy_irq_wake_enable_r <= hwdata_in[PMWRC_PHYIRQ_EN_BIT];
      end
   end
   assign lan_wake_enable_out = lan_wake_enable_r;
   assign phy_irq_wake_enable_out = phy_irq_wake_enable_r;

   // wake statuses: set wins over any clear
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         wake_sts_r <= '0;
      end else if (remote_done && resume_clears_status_r) begin
         wake_sts_r <= wake_sts_set_in;
      end else begin
         wake_sts_r <= wake_sts_r | wake_sts_set_in;
      end
   end
   assign wake_sts_out = wake_sts_r;

   // wake cause: write-one clears, remote resume clears bit one and eee
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         wake_cause_r <= 2'h0;
         eee_cause_r <= 1'b0;
      end else begin
         wake_cause_r <= wake_cause_set_in |
            (wake_cause_r & ~(ctl_wr ? hwdata_in[PMWRC_CAUSE_LO +: 2]
            : 2'h0) & ~{remote_done && resume_clears_status_r,
            1'b0});
         eee_cause_r <= eee_cause_set_in | (eee_cause_r &
            !(ctl_wr && hwdata_in[PMWRC_EEE_CAUSE_BIT]) &
            !(remote_done && resume_clears_status_r));
      end
   end

   // phy reset trigger and hold counter
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         phy_reset_trigger_r <= 1'b0;
         phy_cnt_r <= 32'h00000000;
      end else if (phy_reset_trigger_r) begin
         // writes ignored while high
         if (phy_cnt_r == 32'(PHY_RESET_TRIGGER_CYC - 1)) begin
            phy_reset_trigger_r <= 1'b0;
            phy_cnt_r <= 32'h00000000;
         end else begin
            phy_cnt_r <= phy_cnt_r + 32'h00000001;
         end
      end else if (ctl_wr && hwdata_in[PMWRC_PHY_RESET_TRIGGER_BIT]) begin
         phy_reset_trigger_r <= 1'b1;
      end
   end
   assign phy_reset_pin_low_out = !phy_reset_trigger_r;

   // device ready: low during phy reset, its start, and config load
   always_ff @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         device_ready_r <= 1'b0;
      end else begin
         device_ready_r <= !phy_reset_trigger_r && !cfg_loading_in &&
            !(ctl_wr && hwdata_in[PMWRC_PHY_RESET_TRIGGER_BIT]);
      end
   end
   assign device_ready_out = device_ready_r;

   // phy reset pin held low for at least eight cycles after it falls
   phy_hold_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) $fell(phy_reset_pin_low_out) |->
      !phy_reset_pin_low_out [*8])
      else $error("phy reset pin released early");
   // phy reset count reaches its bound before release
   phy_cnt_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) $rose(phy_reset_pin_low_out) |->
      $past(phy_cnt_r) == 32'(PHY_RESET_TRIGGER_CYC - 1))
      else $error("phy reset released before count done");
   // ready low while phy reset runs
   ready_phy_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) !phy_reset_pin_low_out |=> !device_ready_out)
      else $error("ready high during phy reset");
   // ready low while config loads
   ready_cfg_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) cfg_loading_in |=> !device_ready_out)
      else $error("ready high during config load");
   // unconfigured entry forces state two
   lpsel_force_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) enter_unconfig_in |=>
      low_power_sel_r == PMWRC_LP_TWO)
      else $error("low-power select not forced to two");
   // host resume keeps enables
   host_keep_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) host_done && !ctl_wr |=>
      $stable(lan_wake_enable_r) && $stable(phy_irq_wake_enable_r))
      else $error("host resume changed wake enables");
   // host resume keeps statuses
   host_sts_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) host_done && wake_sts_set_in == '0 |=>
      $stable(wake_sts_r))
      else $error("host resume changed wake status");
   // remote resume clears enables
   enable_clr_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) remote_done && resume_clears_enables_r |=>
      !lan_wake_enable_r && !phy_irq_wake_enable_r)
      else $error("remote resume left wake enables set");
   // remote resume clears statuses
   status_clr_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) remote_done && resume_clears_status_r &&
      wake_sts_set_in == '0 |=> wake_sts_r == '0)
      else $error("remote resume left statuses set");
   // a write of one clears a cause bit
   cause_clr_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) ctl_wr && hwdata_in[0] && !wake_cause_set_in[0] |=>
      !wake_cause_r[0])
      else $error("cause bit not cleared by write of one");

   // checks on the remaining register fields and handshakes
   // a write of zero leaves a cause bit alone
   cause_keep_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) ctl_wr && !hwdata_in[1] && !remote_done &&
      wake_cause_r[1] |=> wake_cause_r[1])
      else $error("cause bit lost on write of zero");
   // remote resume clears cause bit one
   cause1_clr_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) remote_done && resume_clears_status_r &&
      !wake_cause_set_in[1] |=> !wake_cause_r[1])
      else $error("remote resume left cause bit one set");
   // remote resume clears the energy wake cause
   eee_clr_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) remote_done && resume_clears_status_r &&
      !eee_cause_set_in |=> !eee_cause_r)
      else $error("remote resume left energy cause set");
   // statuses kept when the status-clear control is off
   sts_keep_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) !resume_clears_status_r && wake_sts_set_in == '0 |=>
      $stable(wake_sts_r))
      else $error("wake status changed with clearing off");
   // enables move only on a write or a remote resume
   en_keep_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) !ctl_wr && !remote_done |=>
      $stable(lan_wake_enable_r) && $stable(phy_irq_wake_enable_r))
      else $error("wake enables changed without cause");
   // the enable-clear control follows a write
   rce_wr_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) ctl_wr |=>
      resume_clears_enables_r == $past(hwdata_in[PMWRC_RCE_BIT]))
      else $error("enable-clear control missed a write");
   // low-power select follows a write unless unconfigured entry
   lpsel_wr_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) ctl_wr && !enter_unconfig_in |=> low_power_sel_r ==
      $past(hwdata_in[PMWRC_LPSEL_LO +: 2]))
      else $error("low-power select missed a write");
   // code one presented as code zero
   lp_one_map_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) low_power_sel_r == PMWRC_LP_ONE |->
      low_power_sel_out == PMWRC_LP_ZERO)
      else $error("low-power code one not mapped to zero");
   // a write of one starts the phy reset
   phy_start_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) !phy_reset_trigger_r && ctl_wr &&
      hwdata_in[PMWRC_PHY_RESET_TRIGGER_BIT] |=> !phy_reset_pin_low_out)
      else $error("phy reset write did not drive the pin");
   // a rewrite while running does not disturb the pulse
   phy_wr_ign_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) phy_reset_trigger_r && ctl_wr &&
      phy_cnt_r != 32'(PHY_RESET_TRIGGER_CYC - 1) |=> phy_reset_trigger_r)
      else $error("phy reset trigger disturbed by a write");
   // ready drops at the write that starts the phy reset
   ready_drop_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) !phy_reset_trigger_r && ctl_wr &&
      hwdata_in[PMWRC_PHY_RESET_TRIGGER_BIT] |=> !device_ready_out)
      else $error("ready not cleared by phy reset write");
   // ready returns after the pin is released
   ready_back_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) $rose(phy_reset_pin_low_out) && !cfg_loading_in &&
      !(ctl_wr && hwdata_in[PMWRC_PHY_RESET_TRIGGER_BIT]) |=> device_ready_out)
      else $error("ready not restored after phy reset");
   // read data only changes when a read is taken
   rdata_hold_a: assert property (@(posedge clk_sys_in) disable iff
      (!reset_n_in) !rd_go |=> $stable(hrdata_out))
      else $error("read data changed without a read");
endmodule
`default_nettype wire

// *** testbench/pmwrc_phy_model.sv ***
// external phy model: measures how long its reset pin is held low
`timescale 1ns/1ps
`default_nettype none
module pmwrc_phy_model (
   input wire logic clk_in,
   input wire logic reset_n_in,
   input wire logic phy_reset_pin_low_in,
   output logic [31:0] low_len_out
);
   logic [31:0] run_r;
   // count low cycles, latch the length once the pin is released
   always @(posedge clk_in) begin
      if (!reset_n_in) begin
         run_r <= 32'h0;
         low_len_out <= 32'h0;
      end else if (phy_reset_pin_low_in === 1'b0) begin
         run_r <= run_r + 32'h1;
      end else if (run_r != 32'h0) begin
         low_len_out <= run_r;
         run_r <= 32'h0;
      end
   end
endmodule
`default_nettype wire

// *** testbench/test_pmwrc_top.sv ***
// testbench for the power management wake, ready and phy reset block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
   $display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end
module test_pmwrc_top import pmwrc_pkg::*;;
   localparam int RST_CYC = 20;
   logic clk, rst_n, hsel, hwrite, hrdy, hresp, res_done, res_remote;
   logic unconf, cfg_load, eee_set, lan_en, irq_en, ready, pin_low;
   logic [31:0] haddr, hwdata, hrdata, rd, phy_len;
   logic [1:0] htrans, cause_set, lpsel;
   logic [8:0] sts_set, sts;
   int err_total = 0;
   int total_checks = 0;
   pmwrc_top #(.PHY_RESET_TRIGGER_CYC(RST_CYC)) dut (.clk_sys_in(clk),
      .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
      .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
      .hreadyout_out(hrdy), .hresp_out(hresp), .resume_done_in(res_done),
      .resume_remote_in(res_remote), .enter_unconfig_in(unconf),
      .cfg_loading_in(cfg_load), .wake_sts_set_in(sts_set),
      .wake_cause_set_in(cause_set), .eee_cause_set_in(eee_set),
      .wake_sts_out(sts), .low_power_sel_out(lpsel),
      .lan_wake_enable_out(lan_en), .phy_irq_wake_enable_out(irq_en),
      .device_ready_out(ready), .phy_reset_pin_low_out(pin_low));
   pmwrc_phy_model phy (.clk_in(clk), .reset_n_in(rst_n),
      .phy_reset_pin_low_in(pin_low), .low_len_out(phy_len));
   // clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // one ahb-lite single transfer, address phase then data phase
   task automatic ahb(input logic wr, input logic [31:0] a,
         input logic [31:0] d);
      int n;
      hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= wr;
      n = 0;
      do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 50);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      n = 0;
      do begin @(posedge clk); n++; end while (hrdy !== 1'b1 && n < 50);
      rd = hrdata;
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
   endtask
   // raise every wake status and cause for one cycle
   task automatic set_wake();
      sts_set <= 9'h1FF; cause_set <= 2'h3; eee_set <= 1'b1;
      cycles(1);
      sts_set <= 9'h0; cause_set <= 2'h0; eee_set <= 1'b0;
      cycles(1);
   endtask
   task automatic resume(input logic remote);
      res_remote <= remote; res_done <= 1'b1;
      cycles(1);
      res_done <= 1'b0;
      cycles(2);
   endtask
   // reset values, ready held low during config load, unmapped place
   task automatic t_reset();
      cycles(3);
      `CHK(ready, 1'b0)
      cfg_load <= 1'b0;
      cycles(2);
      `CHK(ready, 1'b1)
      `CHK({lpsel, lan_en, irq_en, pin_low}, 5'h11)
      ahb(1'b0, 32'h014, 32'h0);
      `CHK(rd, 32'h000001C0)
      ahb(1'b1, 32'h100, 32'hFFFFFFFF);
      ahb(1'b0, 32'h100, 32'h0);
      `CHK(rd, 32'h0)
   endtask
   // every low-power code, then the unconfigured fallback
   task automatic t_lpsel();
      logic [1:0] c;
      for (int i = 0; i < 4; i++) begin
         c = i[1:0];
         ahb(1'b1, 32'h014, 32'h100 | (32'(c) << 5));
         ahb(1'b0, 32'h014, 32'h0);
         `CHK(rd[6:5], c)
         `CHK(lpsel, (c == 2'h1) ? 2'h0 : c)
      end
      unconf <= 1'b1;
      cycles(1);
      unconf <= 1'b0;
      cycles(1);
      `CHK(lpsel, 2'h2)
      ahb(1'b0, 32'h014, 32'h0); // readback shows the fallback state two
      `CHK(rd[6:5], 2'h2)
   endtask
   // phy reset pulse, rewrite during it, ready after it
   task automatic t_phy();
      int n;
      ahb(1'b1, 32'h014, 32'h150); // start the pulse, keeping state two and enable-clear set
      cycles(1);
      `CHK({pin_low, ready}, 2'h0)
      cycles(5);
      ahb(1'b1, 32'h014, 32'h150);
      ahb(1'b0, 32'h014, 32'h0);
      `CHK(rd[4], 1'b1)
      n = 0;
      while (pin_low !== 1'b1 && n < 100) begin cycles(1); n++; end
      cycles(2);
      `CHK(phy_len, 32'(RST_CYC))
      `CHK(ready, 1'b1)
      ahb(1'b0, 32'h014, 32'h0);
      `CHK(rd[4], 1'b0)
   endtask
   // host and remote resumes with the clearing controls, remote resume without them
   task automatic t_resume();
      ahb(1'b1, 32'h014, 32'h34C);
      set_wake();
      resume(1'b0);
      `CHK({sts, lan_en, irq_en}, 11'h7FF)
      ahb(1'b0, 32'h014, 32'h0);
      `CHK(rd, 32'h000013CF)
      resume(1'b1);
      `CHK({sts, lan_en, irq_en}, 11'h0)
      ahb(1'b0, 32'h014, 32'h0);
      `CHK(rd, 32'h000003C1)
      ahb(1'b0, 32'h020, 32'h0);
      `CHK(rd, 32'h0)
      ahb(1'b1, 32'h014, 32'h04C);
      set_wake();
      resume(1'b1);
      `CHK({sts, lan_en, irq_en}, 11'h7FF)
      ahb(1'b1, 32'h014, 32'h04E);
      ahb(1'b0, 32'h014, 32'h0);
      `CHK(rd, 32'h000010CD)
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog
   initial begin
      #200000;
      err_total++;
      give_verdict();
   end
   // main sequence
   initial begin
      rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
      hwrite = 1'b0; hwdata = 32'h0; res_done = 1'b0; res_remote = 1'b0;
      unconf = 1'b0; cfg_load = 1'b1; sts_set = 9'h0; cause_set = 2'h0;
      eee_set = 1'b0;
      cycles(8);
      `CHK(ready, 1'b0)
      rst_n <= 1'b1;
      t_reset();
      t_lpsel();
      t_phy();
      t_resume();
      give_verdict();
   end
endmodule
`default_nettype wire
